// ### rtl/scgs_pkg.sv
package scgs_pkg;

  // Upload word: address nibble on top, value below
  localparam int ADDR_W = 4;
  localparam int DATA_W = 12;
  localparam int WORD_W = ADDR_W + DATA_W;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } scgs_word_s;

  // Register addresses on the upload ports
  localparam logic [ADDR_W-1:0] REG_CORE_TEST = 4'h0;
  localparam logic [ADDR_W-1:0] REG_AMP_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_COARSE_BLACK = 4'h2;
  localparam logic [ADDR_W-1:0] REG_FINE_BLACK = 4'h3;
  localparam logic [ADDR_W-1:0] REG_CONVERTER = 4'h4;
  localparam logic [ADDR_W-1:0] REG_INT_TIME = 4'h5;
  localparam logic [ADDR_W-1:0] REG_GRANULARITY = 4'h6;
  localparam logic [ADDR_W-1:0] REG_X_START = 4'h7;
  localparam logic [ADDR_W-1:0] REG_Y_START = 4'h8;

  // Register widths
  localparam int CORE_W = 8;
  localparam int AMP_W = 7;
  localparam int DAC_W = 7;
  localparam int CONV_W = 3;
  localparam int GRAN_W = 2;
  localparam int POS_W = 11;
  localparam int ADC_W = 10;

  // Core test and sub-sampling fields
  localparam int TEST_EVEN_BIT = 0;
  localparam int TEST_ODD_BIT = 1;
  localparam int HSUB_LSB = 2;
  localparam int HSUB_MSB = 4;
  localparam int VSUB_LSB = 5;
  localparam int VSUB_MSB = 7;
  localparam int SUB_W = 3;

  // Output amplifier fields
  localparam int AMP_GAIN_LSB = 0;
  localparam int AMP_GAIN_MSB = 3;
  localparam int AMP_UNITY_BIT = 4;
  localparam int AMP_DUAL_BIT = 5;
  localparam int AMP_POWER_BIT = 6;
  localparam int GAIN_W = 4;

  // Converter option fields
  localparam int ADC_OE_BIT = 0;
  localparam int ADC_LINEAR_BIT = 1;
  localparam int ADC_POL_BIT = 2;

  // Reset values
  localparam logic [CORE_W-1:0] CORE_TEST_RESET = 8'h00;
  localparam logic [AMP_W-1:0] AMP_RESET = 7'h00;
  localparam logic [DAC_W-1:0] COARSE_RESET = 7'h00;
  localparam logic [DAC_W-1:0] FINE_RESET = 7'h40;
  localparam logic [CONV_W-1:0] CONV_RESET = 3'h0;
  localparam logic [DATA_W-1:0] INT_TIME_RESET = 12'h00A;
  localparam logic [GRAN_W-1:0] GRAN_RESET = 2'h0;
  localparam logic [POS_W-1:0] POS_RESET = 11'h000;

  // Sequencer phase lengths in granulated periods
  localparam int PHASE_W = 3;
  localparam logic [PHASE_W-1:0] RESET_PERIODS = 3'h4;
  localparam logic [PHASE_W-1:0] PREP_PERIODS = 3'h2;

  // Granulated clock divider: 32, 64, 128 or 256 system clocks
  localparam int DIV_W = 8;

  function automatic logic [DIV_W-1:0] gran_last(
    input logic [GRAN_W-1:0] sel
  );
    case (sel)
      2'h0: gran_last = 8'h1F;
      2'h1: gran_last = 8'h3F;
      2'h2: gran_last = 8'h7F;
      default: gran_last = 8'hFF;
    endcase
  endfunction : gran_last

  // Gamma law: slope two below the knee, one half above
  localparam logic [ADC_W-1:0] GAMMA_KNEE = 10'h100;
  localparam logic [ADC_W-1:0] GAMMA_BASE = 10'h180;

  // Shutter sequencer states
  typedef enum logic [5:0] {
    SEQ_IDLE = 6'h01,
    SEQ_START_HELD = 6'h02,
    SEQ_CORE_RESET = 6'h04,
    SEQ_INTEGRATE = 6'h08,
    SEQ_STOP_HELD = 6'h10,
    SEQ_PREP_READ = 6'h20
  } scgs_seq_e;

  // Image core controls
  typedef struct packed {
    logic tie_odd;
    logic tie_even;
    logic [SUB_W-1:0] hsub;
    logic [SUB_W-1:0] vsub;
  } scgs_core_s;

  // Output amplifier controls
  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic unity;
    logic second_standby;
    logic amp_standby;
  } scgs_amp_s;

endpackage : scgs_pkg

// ### rtl/scgs_gran_div.sv
`timescale 1ns/1ps
`default_nettype none
module scgs_gran_div (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [scgs_pkg::GRAN_W-1:0] gran_sel_in,
  input wire logic restart_in,
  output logic tick_out
);

  typedef struct packed {
    logic [scgs_pkg::DIV_W-1:0] cnt;
    logic tick;
  } scgs_div_s;

  scgs_div_s st_reg;
  scgs_div_s st_next;

  // Free divider; restart realigns phase to the shutter start
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (restart_in) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= scgs_pkg::gran_last(gran_sel_in)) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_out = st_reg.tick;

endmodule : scgs_gran_div
`default_nettype wire

// ### rtl/scgs_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
module scgs_serial_rx (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic select_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_en_in,
  output scgs_pkg::scgs_word_s word_out,
  output logic word_valid_out
);

  typedef struct packed {
    logic [2:0] clk_sync;
    logic [1:0] data_sync;
    logic [2:0] en_sync;
    logic [scgs_pkg::WORD_W-1:0] shift;
    scgs_pkg::scgs_word_s word;
    logic valid;
  } scgs_ser_s;

  scgs_ser_s st_reg;
  scgs_ser_s st_next;

  // Pins are slow (at most 2.5 MHz), so sampling at 10 MHz is safe
  always_comb begin
    st_next = st_reg;
    st_next.clk_sync = {st_reg.clk_sync[1:0], ser_clk_in};
    st_next.data_sync = {st_reg.data_sync[0], ser_data_in};
    st_next.en_sync = {st_reg.en_sync[1:0], ser_en_in};
    st_next.valid = 1'b0;
    if (st_reg.clk_sync[1] && !st_reg.clk_sync[2]) begin
      st_next.shift = {st_reg.shift[scgs_pkg::WORD_W-2:0],
                       st_reg.data_sync[1]};
    end
    if (st_reg.en_sync[1] && !st_reg.en_sync[2] && select_in) begin
      st_next.word = st_reg.shift;
      st_next.valid = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign word_out = st_reg.word;
  assign word_valid_out = st_reg.valid;

endmodule : scgs_serial_rx
`default_nettype wire

// ### rtl/scgs_top.sv
`timescale 1ns/1ps
`default_nettype none
module scgs_top (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic interface_select_pin_in,
  input wire logic serial_select_pin_in,
  input wire logic [scgs_pkg::WORD_W-1:0] par_data_in,
  input wire logic par_write_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_en_in,
  input wire logic shutter_start_in,
  input wire logic shutter_stop_in,
  input wire logic [scgs_pkg::ADC_W-1:0] adc_sample_in,
  output scgs_pkg::scgs_core_s core_out,
  output scgs_pkg::scgs_amp_s amp_out,
  output logic [scgs_pkg::DAC_W-1:0] coarse_level_out,
  output logic [scgs_pkg::DAC_W-1:0] fine_level_out,
  output logic [scgs_pkg::ADC_W-1:0] adc_data_out,
  output logic adc_data_oe_n_out,
  output logic [scgs_pkg::POS_W-1:0] x_start_out,
  output logic [scgs_pkg::POS_W-1:0] y_start_out,
  output logic timeout_out,
  output logic core_reset_out,
  output logic integrating_out,
  output logic core_readable_out,
  output logic seq_suspended_out
);

  typedef struct packed {
    // Pin synchronisers
    logic [1:0] if_sync;
    logic [1:0] ser_sync;
    logic [scgs_pkg::WORD_W-1:0] pdata_meta;
    logic [scgs_pkg::WORD_W-1:0] pdata_sync;
    logic [2:0] pwr_sync;
    logic [2:0] start_sync;
    logic [1:0] stop_sync;
    // Registers written over the upload ports
    logic [scgs_pkg::CORE_W-1:0] core_test;
    logic [scgs_pkg::AMP_W-1:0] amp_ctrl;
    logic [scgs_pkg::DAC_W-1:0] coarse;
    logic [scgs_pkg::DAC_W-1:0] fine;
    logic [scgs_pkg::CONV_W-1:0] conv;
    logic [scgs_pkg::DATA_W-1:0] int_time;
    logic [scgs_pkg::GRAN_W-1:0] gran;
    logic [scgs_pkg::POS_W-1:0] x_start;
    logic [scgs_pkg::POS_W-1:0] y_start;
    // Shutter sequencer
    scgs_pkg::scgs_seq_e seq;
    logic [scgs_pkg::DATA_W-1:0] int_cnt;
    logic [scgs_pkg::PHASE_W-1:0] phase;
    logic timeout;
    // Registered outputs
    scgs_pkg::scgs_amp_s amp_q;
    logic [scgs_pkg::ADC_W-1:0] adc_q;
    logic adc_oe_n;
  } scgs_top_s;

  scgs_top_s st_reg;
  scgs_top_s st_next;

  logic ser_select;
  logic gran_tick;
  logic start_fall;
  scgs_pkg::scgs_word_s ser_word;
  logic ser_valid;
  scgs_pkg::scgs_word_s par_word;
  logic par_valid;
  scgs_pkg::scgs_word_s up_word;
  logic up_valid;
  logic [scgs_pkg::ADC_W-1:0] adc_shaped;

  assign ser_select = !st_reg.if_sync[1] && st_reg.ser_sync[1];

  scgs_serial_rx u_serial (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .select_in(ser_select),
    .ser_clk_in(ser_clk_in),
    .ser_data_in(ser_data_in),
    .ser_en_in(ser_en_in),
    .word_out(ser_word),
    .word_valid_out(ser_valid)
  );

  // divider phase aligned to start release
  assign start_fall = st_reg.start_sync[2] && !st_reg.start_sync[1];

  scgs_gran_div u_gran (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .gran_sel_in(st_reg.gran),
    .restart_in(start_fall),
    .tick_out(gran_tick)
  );

  // parallel word taken on write strobe rise
  assign par_word = st_reg.pdata_sync;
  assign par_valid = st_reg.if_sync[1] && st_reg.pwr_sync[1] &&
                     !st_reg.pwr_sync[2];
  assign up_word = par_valid ? par_word : ser_word;
  assign up_valid = par_valid || ser_valid;

  always_comb begin
    if (st_reg.conv[scgs_pkg::ADC_LINEAR_BIT]) begin
      adc_shaped = adc_sample_in;
    end else if (adc_sample_in < scgs_pkg::GAMMA_KNEE) begin
      adc_shaped = {adc_sample_in[scgs_pkg::ADC_W-2:0], 1'b0};
    end else begin
      adc_shaped = scgs_pkg::GAMMA_BASE +
                   {1'b0, adc_sample_in[scgs_pkg::ADC_W-1:1]};
    end
  end

  // Next state: upload decode, sequencer, output shaping
  always_comb begin
    st_next = st_reg;
    st_next.if_sync = {st_reg.if_sync[0], interface_select_pin_in};
    st_next.ser_sync = {st_reg.ser_sync[0], serial_select_pin_in};
    st_next.pdata_meta = par_data_in;
    st_next.pdata_sync = st_reg.pdata_meta;
    st_next.pwr_sync = {st_reg.pwr_sync[1:0], par_write_in};
    st_next.start_sync = {st_reg.start_sync[1:0], shutter_start_in};
    st_next.stop_sync = {st_reg.stop_sync[0], shutter_stop_in};

    // Write decode; unknown addresses are ignored
    if (up_valid) begin
      case (up_word.addr)
        scgs_pkg::REG_CORE_TEST: begin
          st_next.core_test = up_word.data[scgs_pkg::CORE_W-1:0];
        end
        scgs_pkg::REG_AMP_CTRL: begin
          st_next.amp_ctrl = up_word.data[scgs_pkg::AMP_W-1:0];
        end
        scgs_pkg::REG_COARSE_BLACK: begin
          st_next.coarse = up_word.data[scgs_pkg::DAC_W-1:0];
        end
        scgs_pkg::REG_FINE_BLACK: begin
          st_next.fine = up_word.data[scgs_pkg::DAC_W-1:0];
        end
        scgs_pkg::REG_CONVERTER: begin
          st_next.conv = up_word.data[scgs_pkg::CONV_W-1:0];
        end
        scgs_pkg::REG_INT_TIME: begin
          st_next.int_time = up_word.data;
        end
        scgs_pkg::REG_GRANULARITY: begin
          st_next.gran = up_word.data[scgs_pkg::GRAN_W-1:0];
        end
        scgs_pkg::REG_X_START: begin
          st_next.x_start = {up_word.data[scgs_pkg::POS_W-1:1], 1'b0};
        end
        scgs_pkg::REG_Y_START: begin
          st_next.y_start = up_word.data[scgs_pkg::POS_W-1:0];
        end
        default: begin
          st_next.gran = st_reg.gran;
        end
      endcase
    end

    // timeout ends after one granulated period
    if (gran_tick) begin
      st_next.timeout = 1'b0;
    end

    case (st_reg.seq)
      scgs_pkg::SEQ_START_HELD: begin
        if (!st_reg.start_sync[1]) begin
          st_next.seq = scgs_pkg::SEQ_CORE_RESET;
          st_next.phase = '0;
          st_next.int_cnt = '0;
        end
      end
      scgs_pkg::SEQ_CORE_RESET, scgs_pkg::SEQ_INTEGRATE: begin
        if (gran_tick) begin
          st_next.int_cnt = st_reg.int_cnt + 12'h001;
          if (st_reg.phase == scgs_pkg::RESET_PERIODS - 3'h1) begin
            st_next.seq = scgs_pkg::SEQ_INTEGRATE;
          end else if (st_reg.seq == scgs_pkg::SEQ_CORE_RESET) begin
            st_next.phase = st_reg.phase + 3'h1;
          end
          if (st_reg.int_cnt + 12'h001 == st_reg.int_time) begin
            st_next.timeout = 1'b1;
          end
        end
      end
      scgs_pkg::SEQ_STOP_HELD: begin
        if (!st_reg.stop_sync[1]) begin
          st_next.seq = scgs_pkg::SEQ_PREP_READ;
          st_next.phase = '0;
        end
      end
      scgs_pkg::SEQ_PREP_READ: begin
        if (gran_tick) begin
          if (st_reg.phase == scgs_pkg::PREP_PERIODS - 3'h1) begin
            st_next.seq = scgs_pkg::SEQ_IDLE;
          end else begin
            st_next.phase = st_reg.phase + 3'h1;
          end
        end
      end
      scgs_pkg::SEQ_IDLE: begin
        st_next.phase = '0;
      end
      default: begin
        st_next.seq = scgs_pkg::SEQ_IDLE;
      end
    endcase

    // Stop wins over start; start restarts from any state, stop from any state except idle and read preparation
    if (st_reg.stop_sync[1] && st_reg.seq != scgs_pkg::SEQ_IDLE &&
        st_reg.seq != scgs_pkg::SEQ_PREP_READ) begin
      st_next.seq = scgs_pkg::SEQ_STOP_HELD;
    end else if (st_reg.start_sync[1]) begin
      st_next.seq = scgs_pkg::SEQ_START_HELD;
      st_next.timeout = 1'b0;
    end

    st_next.amp_q.gain =
      st_reg.amp_ctrl[scgs_pkg::AMP_UNITY_BIT] ? '0 :
      st_reg.amp_ctrl[scgs_pkg::AMP_GAIN_MSB:scgs_pkg::AMP_GAIN_LSB];
    st_next.amp_q.unity = st_reg.amp_ctrl[scgs_pkg::AMP_UNITY_BIT];
    // second path idle in single output
    st_next.amp_q.second_standby =
      !st_reg.amp_ctrl[scgs_pkg::AMP_DUAL_BIT] ||
      !st_reg.amp_ctrl[scgs_pkg::AMP_POWER_BIT];
    st_next.amp_q.amp_standby = !st_reg.amp_ctrl[scgs_pkg::AMP_POWER_BIT];

    st_next.adc_q = st_reg.conv[scgs_pkg::ADC_POL_BIT] ?
                    adc_shaped : ~adc_shaped;
    st_next.adc_oe_n = !st_reg.conv[scgs_pkg::ADC_OE_BIT];
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_reg <= '0;
      st_reg.core_test <= scgs_pkg::CORE_TEST_RESET;
      st_reg.amp_ctrl <= scgs_pkg::AMP_RESET;
      st_reg.coarse <= scgs_pkg::COARSE_RESET;
      st_reg.fine <= scgs_pkg::FINE_RESET;
      st_reg.conv <= scgs_pkg::CONV_RESET;
      st_reg.int_time <= scgs_pkg::INT_TIME_RESET;
      st_reg.gran <= scgs_pkg::GRAN_RESET;
      st_reg.x_start <= scgs_pkg::POS_RESET;
      st_reg.y_start <= scgs_pkg::POS_RESET;
      st_reg.seq <= scgs_pkg::SEQ_IDLE;
      st_reg.amp_q.amp_standby <= 1'b1;
      st_reg.amp_q.second_standby <= 1'b1;
      st_reg.adc_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign core_out.tie_odd = st_reg.core_test[scgs_pkg::TEST_ODD_BIT];
  assign core_out.tie_even = st_reg.core_test[scgs_pkg::TEST_EVEN_BIT];
  assign core_out.hsub =
    st_reg.core_test[scgs_pkg::HSUB_MSB:scgs_pkg::HSUB_LSB];
  assign core_out.vsub =
    st_reg.core_test[scgs_pkg::VSUB_MSB:scgs_pkg::VSUB_LSB];
  assign amp_out = st_reg.amp_q;
  // coarse code drives offset DAC directly
  assign coarse_level_out = st_reg.coarse;
  // fine code, mid-scale means no trim
  assign fine_level_out = st_reg.fine;
  assign adc_data_out = st_reg.adc_q;
  assign adc_data_oe_n_out = st_reg.adc_oe_n;
  assign x_start_out = st_reg.x_start;
  assign y_start_out = st_reg.y_start;
  assign timeout_out = st_reg.timeout;
  assign core_reset_out = st_reg.seq == scgs_pkg::SEQ_CORE_RESET;
  assign integrating_out = st_reg.seq == scgs_pkg::SEQ_INTEGRATE;
  assign core_readable_out = st_reg.seq == scgs_pkg::SEQ_IDLE;
  assign seq_suspended_out = st_reg.seq == scgs_pkg::SEQ_START_HELD ||
                             st_reg.seq == scgs_pkg::SEQ_STOP_HELD;

endmodule : scgs_top
`default_nettype wire

// ### verif/scgs_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module scgs_top_asserts (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic par_write_in,
  input wire logic ser_en_in,
  input wire logic shutter_start_in,
  input wire scgs_pkg::scgs_core_s core_out,
  input wire scgs_pkg::scgs_amp_s amp_out,
  input wire logic [scgs_pkg::DAC_W-1:0] coarse_level_out,
  input wire logic [scgs_pkg::DAC_W-1:0] fine_level_out,
  input wire logic adc_data_oe_n_out,
  input wire logic [scgs_pkg::POS_W-1:0] x_start_out,
  input wire logic [scgs_pkg::POS_W-1:0] y_start_out,
  input wire logic timeout_out,
  input wire logic core_reset_out,
  input wire logic integrating_out,
  input wire logic core_readable_out,
  input wire logic seq_suspended_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic [8:0] to_len_reg;
  logic [10:0] cr_len_reg;
  logic [3:0] since_reg;
  // Run lengths and age of the last write; age saturates, never wraps
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      to_len_reg <= 9'h000;
      cr_len_reg <= 11'h000;
      since_reg <= 4'hF;
    end else begin
      to_len_reg <= timeout_out ? to_len_reg + 9'h001 : 9'h000;
      cr_len_reg <= core_reset_out ? cr_len_reg + 11'h001 : 11'h000;
      if (par_write_in || ser_en_in) since_reg <= 4'h0;
      else if (since_reg != 4'hF) since_reg <= since_reg + 4'h1;
    end
  end
  a_timeout_width: assert property (
    $fell(timeout_out) |-> to_len_reg inside {32, 64, 128, 256})
    else $error("timeout width is not one tick");
  // Slack of two cycles for the divider restart
  a_reset_phase: assert property (
    $fell(core_reset_out) && integrating_out |-> cr_len_reg inside
    {[126:130], [254:258], [510:514], [1022:1026]})
    else $error("core reset phase is not four ticks");
  a_seq_onehot: assert property (
    $onehot0({core_reset_out, integrating_out, core_readable_out}))
    else $error("sequencer phases overlap");
  a_start_suspend: assert property (
    shutter_start_in [*3] |-> ##2 seq_suspended_out)
    else $error("sequencer not suspended under start");
  a_timeout_integ: assert property (
    $rose(timeout_out) |-> integrating_out)
    else $error("timeout outside integration");
  a_x_even: assert property (x_start_out[0] == 1'b0)
    else $error("odd column start");
  a_unity_gain: assert property (amp_out.unity |-> amp_out.gain == 4'h0)
    else $error("gain not bypassed in unity");
  a_standby_pair: assert property (
    amp_out.amp_standby |-> amp_out.second_standby)
    else $error("second path awake while amplifier off");
  a_cfg_cause: assert property (
    !$stable({core_out, amp_out, coarse_level_out, fine_level_out,
    adc_data_oe_n_out, x_start_out, y_start_out}) |-> since_reg < 4'hA)
    else $error("setting changed without a transfer");
  c_timeout: cover property ($rose(timeout_out));
  c_readable: cover property ($rose(core_readable_out));
  c_unity: cover property (amp_out.unity);
endmodule : scgs_top_asserts
`default_nettype wire

// ### verif/scgs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module scgs_ctrl_model #(
  parameter int STOP_DELAY = 300
) (
  input wire logic clock_in,
  input wire logic fire_in,
  input wire logic timeout_in,
  output logic shutter_start_out,
  output logic shutter_stop_out
);
  initial begin
    shutter_start_out = 1'b0;
    shutter_stop_out = 1'b0;
  end
  // start pulse of three cycles, moved on falling edges
  always @(posedge clock_in) begin
    if (fire_in) begin
      @(negedge clock_in);
      shutter_start_out <= 1'b1;
      repeat (3) @(negedge clock_in);
      shutter_start_out <= 1'b0;
    end
  end
  // stop derived from timeout after a delay, never wired to it
  always begin
    @(posedge timeout_in);
    repeat (STOP_DELAY) @(negedge clock_in);
    shutter_stop_out <= 1'b1;
    repeat (2) @(negedge clock_in);
    shutter_stop_out <= 1'b0;
  end
endmodule : scgs_ctrl_model
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic interface_select_pin_in = 1'b1;
  logic serial_select_pin_in = 1'b0;
  logic [15:0] par_data_in = 16'h0000;
  logic par_write_in = 1'b0;
  logic ser_clk_in = 1'b0;
  logic ser_data_in = 1'b0;
  logic ser_en_in = 1'b0;
  logic fire = 1'b0;
  logic [9:0] adc_sample_in = 10'h000;
  logic shutter_start_in, shutter_stop_in, adc_data_oe_n_out;
  logic timeout_out, core_reset_out, integrating_out;
  logic core_readable_out, seq_suspended_out;
  scgs_pkg::scgs_core_s core_out;
  scgs_pkg::scgs_amp_s amp_out;
  logic [6:0] coarse_level_out, fine_level_out;
  logic [9:0] adc_data_out;
  logic [10:0] x_start_out, y_start_out;
  int num_errors = 0;
  int n_compared = 0;
  int n1, n2, n3, t;
  logic [7:0] cv [3] = '{8'h01, 8'h02, 8'hB5};
  logic [6:0] av [4] = '{7'h4A, 7'h7A, 7'h2F, 7'h60};
  logic [6:0] dv [3] = '{7'h7F, 7'h00, 7'h41};
  logic [9:0] sv [4] = '{10'h000, 10'h0FF, 10'h100, 10'h3FF};
  logic [2:0] cfg;
  scgs_top uut (.clock_in, .reset_in, .interface_select_pin_in,
    .serial_select_pin_in, .par_data_in, .par_write_in, .ser_clk_in,
    .ser_data_in, .ser_en_in, .shutter_start_in, .shutter_stop_in,
    .adc_sample_in, .core_out, .amp_out, .coarse_level_out,
    .fine_level_out, .adc_data_out, .adc_data_oe_n_out, .x_start_out,
    .y_start_out, .timeout_out, .core_reset_out, .integrating_out,
    .core_readable_out, .seq_suspended_out);
  scgs_ctrl_model ctrl (.clock_in, .fire_in(fire),
    .timeout_in(timeout_out), .shutter_start_out(shutter_start_in),
    .shutter_stop_out(shutter_stop_in));
  // 10 MHz system clock
  always #50 clock_in = ~clock_in;
  task automatic print_verdict();
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Word settles three cycles ahead of the strobe, then goes stale
  task automatic wr_par(input logic [3:0] a, input logic [11:0] d);
    par_data_in = {a, d};
    repeat (3) @(negedge clock_in);
    par_write_in = 1'b1;
    repeat (4) @(negedge clock_in);
    par_write_in = 1'b0;
    par_data_in = ~{a, d};
    repeat (6) @(negedge clock_in);
  endtask : wr_par
  task automatic wr_ser(input logic [3:0] a, input logic [11:0] d,
                        input int nb, input logic en);
    logic [15:0] w;
    w = {a, d};
    for (int i = 15; i > 15 - nb; i--) begin
      ser_data_in = w[i];
      repeat (3) @(negedge clock_in);
      ser_clk_in = 1'b1;
      repeat (3) @(negedge clock_in);
      ser_clk_in = 1'b0;
    end
    // Data goes stale once the last bit is clocked in
    ser_data_in = ~ser_data_in;
    if (en) begin
      repeat (3) @(negedge clock_in);
      ser_en_in = 1'b1;
      repeat (4) @(negedge clock_in);
      ser_en_in = 1'b0;
    end
    repeat (8) @(negedge clock_in);
  endtask : wr_ser
  function automatic logic sig(input int k);
    case (k)
      0: sig = shutter_start_in;
      1: sig = integrating_out;
      2: sig = timeout_out;
      3: sig = shutter_stop_in;
      default: sig = core_readable_out;
    endcase
  endfunction : sig
  // Bounded wait; a hang ends the run as a mismatch
  task automatic wait_for(input int k, input logic lvl, output int n);
    n = 0;
    while (sig(k) !== lvl && n < 5000) begin
      @(negedge clock_in);
      n++;
    end
    if (n >= 5000) begin
      num_errors++;
      print_verdict();
    end
  endtask : wait_for
  function automatic logic [9:0] adc_exp(input logic [2:0] c,
                                         input logic [9:0] x);
    logic [9:0] y;
    y = c[1] ? x : (x < 10'h100 ? {x[8:0], 1'b0} : 10'h180 + (x >> 1));
    adc_exp = c[2] ? y : ~y;
  endfunction : adc_exp
  initial begin
    repeat (10) @(negedge clock_in);
    reset_in = 1'b0;
    @(negedge clock_in);
    check(core_out, 16'h0000);
    check(amp_out, 16'h0003);
    check(coarse_level_out, 16'h0000);
    check(fine_level_out, 16'h0040);
    check(adc_data_oe_n_out, 16'h0001);
    check(core_readable_out, 16'h0001);
    foreach (cv[i]) begin
      wr_par(scgs_pkg::REG_CORE_TEST, {4'h0, cv[i]});
      check(core_out, {8'h00, cv[i][1:0], cv[i][4:2], cv[i][7:5]});
    end
    foreach (av[i]) begin
      wr_par(scgs_pkg::REG_AMP_CTRL, {5'h00, av[i]});
      check(amp_out,
        {9'h000, av[i][4] ? 4'h0 : av[i][3:0], av[i][4],
        ~av[i][5] | ~av[i][6], ~av[i][6]});
    end
    foreach (dv[i]) begin
      wr_par(scgs_pkg::REG_COARSE_BLACK, {5'h00, dv[i]});
      wr_par(scgs_pkg::REG_FINE_BLACK, {5'h00, dv[i]});
      check(coarse_level_out, {9'h000, dv[i]});
      check(fine_level_out, {9'h000, dv[i]});
    end
    for (int c = 0; c < 8; c++) begin
      cfg = 3'(c);
      wr_par(scgs_pkg::REG_CONVERTER, {9'h000, cfg});
      check(adc_data_oe_n_out, {15'h0000, ~cfg[0]});
      foreach (sv[i]) begin
        adc_sample_in = sv[i];
        repeat (2) @(negedge clock_in);
        if (cfg[0]) check(adc_data_out, adc_exp(cfg, sv[i]));
      end
    end
    wr_par(scgs_pkg::REG_X_START, 12'h123);
    check(x_start_out, 16'h0122);
    wr_par(scgs_pkg::REG_Y_START, 12'h3FF);
    check(y_start_out, 16'h03FF);
    wr_par(4'hF, 12'h055);
    check(coarse_level_out, 16'h0041);
    interface_select_pin_in = 1'b0;
    wr_par(scgs_pkg::REG_COARSE_BLACK, 12'h055);
    check(coarse_level_out, 16'h0041);
    serial_select_pin_in = 1'b1;
    wr_ser(scgs_pkg::REG_COARSE_BLACK, 12'h02A, 16, 1'b1);
    check(coarse_level_out, 16'h002A);
    wr_ser(scgs_pkg::REG_COARSE_BLACK, 12'h011, 8, 1'b0);
    check(coarse_level_out, 16'h002A);
    interface_select_pin_in = 1'b1;
    wr_ser(scgs_pkg::REG_COARSE_BLACK, 12'h033, 16, 1'b1);
    check(coarse_level_out, 16'h002A);
    wr_par(scgs_pkg::REG_INT_TIME, 12'h00A);
    for (int g = 0; g < 4; g++) begin
      t = 32 << g;
      wr_par(scgs_pkg::REG_GRANULARITY, 12'(g));
      fire = 1'b1;
      @(negedge clock_in);
      fire = 1'b0;
      wait_for(0, 1'b1, n1);
      wait_for(0, 1'b0, n1);
      wait_for(1, 1'b1, n1);
      check(16'(n1 >= 4 * t - 2 && n1 <= 4 * t + 8), 16'h0001);
      wait_for(2, 1'b1, n2);
      check(16'(n1 + n2 >= 10 * t - 2 && n1 + n2 <= 10 * t + 8),
        16'h0001);
      wait_for(2, 1'b0, n3);
      check(16'(n3), 16'(t));
      wait_for(3, 1'b1, n1);
      wait_for(3, 1'b0, n1);
      wait_for(4, 1'b1, n3);
      check(16'(n3 >= t && n3 <= 2 * t + 6), 16'h0001);
    end
    print_verdict();
  end
endmodule : tb
bind scgs_top scgs_top_asserts chk (.clock_in, .reset_in, .par_write_in,
  .ser_en_in, .shutter_start_in, .core_out, .amp_out, .coarse_level_out,
  .fine_level_out, .adc_data_oe_n_out, .x_start_out, .y_start_out,
  .timeout_out, .core_reset_out, .integrating_out, .core_readable_out,
  .seq_suspended_out);
`default_nettype wire
